// ---- logic/odp_regs.vh ----
// register map, field positions and reset values for the output driver protect bank
`ifndef ODP_REGS_VH
`define ODP_REGS_VH
`define ODP_ADDR_PAGE 8'h00
`define ODP_ADDR_PIN_GAIN 8'h75
`define ODP_ADDR_ERR_CTRL 8'h1e
`define ODP_ADDR_HP_CTRL 8'h1f
`define ODP_PAGE_ZERO 8'h00
`define ODP_PAGE_ONE 8'h01
`define ODP_PAGE_RST 8'h00
`define ODP_ERR_RST 2'h0
`define ODP_HP_RST 8'h04
`define ODP_HP_WMASK 8'hde
`define ODP_ERR_SP_KEEP 1
`define ODP_ERR_HP_KEEP 0
`define ODP_HP_LEFT_PU 7
`define ODP_HP_RIGHT_PU 6
`define ODP_HP_CM_HI 4
`define ODP_HP_CM_LO 3
`define ODP_HP_RSVD_ONE 2
`define ODP_HP_SHORT_PD 1
`define ODP_HP_SHORT_ST 0
`define ODP_GAIN_RESERVED 7'h7f
`define ODP_GAIN_RST 7'h7f
`define ODP_CM_RST 2'h0
`endif

// ---- logic/odp_short_policy.v ----
// short-circuit response policy for speaker and headphone power-up bits
`timescale 1ns/1ps
module odp_short_policy (
   input wire sp_short_det,
   input wire hp_short_det,
   input wire sp_keep,
   input wire hp_keep,
   input wire hp_short_pd,
   output wire sp_clear,
   output wire hp_clear
);
   // speaker clear unless the keep bit is set
   assign sp_clear = sp_short_det & ~sp_keep;
   // headphone clear only in power-down mode, otherwise current limit
   assign hp_clear = hp_short_det & ~hp_keep & hp_short_pd;
endmodule

// ---- logic/odp_regbank.v ----
// register bank for pin gain readback, page select and driver short protection
// Notes on behaviour
// - gain readback: 7-bit code, all-ones reserved
// - page register selects 256 pages, resets zero
// - error bit1 low: clear speaker power-ups
// - error bit0 low: clear headphone power-ups when bit1 of the headphone register selects power-down
// - headphone bits 7,6 power up drivers
// - common-mode field 00..11, 1.35 to 1.8V
// - short: limit current or power down
// - bit0 reads live headphone short status
`timescale 1ns/1ps
`include "odp_regs.vh"
module odp_regbank (
   core_clk,
   rst,
   reg_wr,
   reg_rd,
   reg_addr,
   reg_wdata,
   reg_rdata,
   page_sel,
   pin_gain_code,
   pin_gain_valid,
   sp_short_det,
   hp_short_det,
   sp_pu_clear,
   left_headphone_driver_pu,
   right_headphone_driver_pu,
   hp_common_mode,
   hp_short_pd_mode,
   hp_short_current_limit
);
   input wire core_clk;
   input wire rst;
   input wire reg_wr;
   input wire reg_rd;
   input wire [7:0] reg_addr;
   input wire [7:0] reg_wdata;
   output reg [7:0] reg_rdata;
   output reg [7:0] page_sel;
   input wire [6:0] pin_gain_code;
   input wire pin_gain_valid;
   input wire sp_short_det;
   input wire hp_short_det;
   output reg sp_pu_clear;
   output reg left_headphone_driver_pu;
   output reg right_headphone_driver_pu;
   output reg [1:0] hp_common_mode;
   output reg hp_short_pd_mode;
   output reg hp_short_current_limit;

   reg [7:0] page_r;
   reg [1:0] err_ctrl_r;
   reg [7:0] hp_ctrl_r;
   reg [6:0] gain_r;
   reg hp_short_r;
   reg [7:0] hp_ctrl_nxt;
   reg [7:0] rdata_nxt;
   wire sp_clear;
   wire hp_clear;

   // address decode against the current page
   function sel;
      input [7:0] pg;
      input [7:0] ad;
      input [7:0] want_pg;
      input [7:0] want_ad;
      begin
         sel = (pg == want_pg) && (ad == want_ad);
      end
   endfunction

   odp_short_policy u_policy (
      .sp_short_det(sp_short_det),
      .hp_short_det(hp_short_det),
      .sp_keep(err_ctrl_r[`ODP_ERR_SP_KEEP]),
      .hp_keep(err_ctrl_r[`ODP_ERR_HP_KEEP]),
      .hp_short_pd(hp_ctrl_r[`ODP_HP_SHORT_PD]),
      .sp_clear(sp_clear),
      .hp_clear(hp_clear)
   );

   // headphone control: write first, then short clear wins over write
   always @* begin
      hp_ctrl_nxt = hp_ctrl_r;
      if (reg_wr && sel(page_r, reg_addr, `ODP_PAGE_ONE, `ODP_ADDR_HP_CTRL)) begin
         // status bit 0 and reserved bit 5 are not stored
         hp_ctrl_nxt = (reg_wdata & `ODP_HP_WMASK) | (hp_ctrl_r & ~`ODP_HP_WMASK);
      end
      if (hp_clear) begin
         // hardware clear beats a same-cycle software power-up
         hp_ctrl_nxt[`ODP_HP_LEFT_PU] = 1'b0;
         hp_ctrl_nxt[`ODP_HP_RIGHT_PU] = 1'b0;
      end
   end

   // read mux; page register is visible on every page
   always @* begin
      rdata_nxt = 8'h00;
      if (reg_addr == `ODP_ADDR_PAGE) begin
         rdata_nxt = page_r;
      end else if (sel(page_r, reg_addr, `ODP_PAGE_ZERO, `ODP_ADDR_PIN_GAIN)) begin
         rdata_nxt = {1'b0, gain_r};
      end else if (sel(page_r, reg_addr, `ODP_PAGE_ONE, `ODP_ADDR_ERR_CTRL)) begin
         rdata_nxt = {6'h00, err_ctrl_r};
      end else if (sel(page_r, reg_addr, `ODP_PAGE_ONE, `ODP_ADDR_HP_CTRL)) begin
         rdata_nxt = {hp_ctrl_r[7:1], hp_short_r};
      end
   end

   // register state
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         page_r <= `ODP_PAGE_RST;
         err_ctrl_r <= `ODP_ERR_RST;
         hp_ctrl_r <= `ODP_HP_RST;
         gain_r <= `ODP_GAIN_RST;
         hp_short_r <= 1'b0;
         reg_rdata <= 8'h00;
         page_sel <= `ODP_PAGE_RST;
         sp_pu_clear <= 1'b0;
         left_headphone_driver_pu <= 1'b0;
         right_headphone_driver_pu <= 1'b0;
         hp_common_mode <= `ODP_CM_RST;
         hp_short_pd_mode <= 1'b0;
         hp_short_current_limit <= 1'b0;
      end else begin
         // page write applies to the very next access; page contents stay put
         if (reg_wr && reg_addr == `ODP_ADDR_PAGE) begin
            page_r <= reg_wdata;
         end
         if (reg_wr && sel(page_r, reg_addr, `ODP_PAGE_ONE, `ODP_ADDR_ERR_CTRL)) begin
            err_ctrl_r <= reg_wdata[1:0];
         end
         hp_ctrl_r <= hp_ctrl_nxt;
         // the converter holds the last sampled code
         if (pin_gain_valid) begin
            gain_r <= pin_gain_code;
         end
         hp_short_r <= hp_short_det;
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
         page_sel <= page_r;
         sp_pu_clear <= sp_clear;
         left_headphone_driver_pu <= hp_ctrl_nxt[`ODP_HP_LEFT_PU];
         right_headphone_driver_pu <= hp_ctrl_nxt[`ODP_HP_RIGHT_PU];
         hp_common_mode <= hp_ctrl_nxt[`ODP_HP_CM_HI:`ODP_HP_CM_LO];
         hp_short_pd_mode <= hp_short_det & hp_ctrl_r[`ODP_HP_SHORT_PD];
         hp_short_current_limit <= hp_short_det & ~hp_ctrl_r[`ODP_HP_SHORT_PD];
      end
   end
endmodule

// ---- dv/odp_props.sv ----
// port assertions and covers for the driver protect register bank
`timescale 1ns/1ps
module odp_props (
   input wire core_clk,
   input wire rst,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire [7:0] page_sel,
   input wire sp_short_det,
   input wire hp_short_det,
   input wire sp_pu_clear,
   input wire left_headphone_driver_pu,
   input wire right_headphone_driver_pu,
   input wire [1:0] hp_common_mode,
   input wire hp_short_pd_mode,
   input wire hp_short_current_limit
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // quiet write to the headphone register; a short could clear it
   sequence hp_wr_s;
      reg_wr && reg_addr == 8'h1f && page_sel == 8'h01 && !hp_short_det ##1 !hp_short_det;
   endsequence
   chk_page_follow: assert property (reg_wr && reg_addr == 8'h00 |-> ##2 page_sel == $past(reg_wdata, 2))
      else $error("page_sel did not follow page write");
   chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h50 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   chk_mode_excl: assert property (!(hp_short_pd_mode && hp_short_current_limit))
      else $error("both short responses active");
   chk_mode_cause: assert property (hp_short_pd_mode || hp_short_current_limit |-> $past(hp_short_det))
      else $error("short response without short");
   chk_idle_quiet: assert property (!hp_short_det [*2] |-> !hp_short_pd_mode && !hp_short_current_limit)
      else $error("short response stuck");
   chk_sp_cause: assert property (sp_pu_clear |-> $past(sp_short_det))
      else $error("speaker clear without short");
   chk_hp_pu_write: assert property (hp_wr_s |-> {left_headphone_driver_pu, right_headphone_driver_pu} == $past(reg_wdata[7:6]))
      else $error("power-up bits wrong after write");
   chk_cm_write: assert property (hp_wr_s |-> hp_common_mode == $past(reg_wdata[4:3]))
      else $error("common-mode wrong after write");
   cover property (hp_short_pd_mode);
   cover property (hp_short_current_limit);
   cover property (sp_pu_clear);
endmodule

// ---- dv/output_driver_protect_regs_test.sv ----
// self-checking bench for the driver protect register bank
`timescale 1ns/1ps
module output_driver_protect_regs_test;
   logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pin_gain_valid = 0, clr;
   logic sp_short_det = 0, hp_short_det = 0, sp_pu_clear, lpu, rpu, pd, lim;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, page_sel, v;
   logic [6:0] pin_gain_code = 0;
   logic [1:0] cm;
   int n_fail = 0, checked = 0, i;
   odp_regbank dut (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .page_sel, .pin_gain_code, .pin_gain_valid, .sp_short_det, .hp_short_det, .sp_pu_clear,
      .left_headphone_driver_pu(lpu), .right_headphone_driver_pu(rpu), .hp_common_mode(cm),
      .hp_short_pd_mode(pd), .hp_short_current_limit(lim));
   always #20 core_clk = ~core_clk;
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // extra idle edge keeps page_sel settled before the next access
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge core_clk) reg_wr <= 0;
      @(posedge core_clk) #1;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge core_clk) reg_rd <= 0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask
   task automatic end_sim;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      v = 8'($urandom(32'hcd1a));
      repeat (5) @(posedge core_clk);
      rst <= 0;
      rd(8'h00, 8'h00);
      wr(8'h00, 8'h01);
      chk("page_sel", 8'h01, page_sel);
      rd(8'h1f, 8'h04);
      rd(8'h1e, 8'h00);
      rd(8'h50, 8'h00);
      // every common-mode code with random power-up and short-mode bits
      for (i = 0; i < 4; i++) begin
         v = 8'($urandom) & 8'hc2 | 8'h04 | {3'h0, i[1:0], 3'h0};
         wr(8'h1f, v);
         chk("hp_outputs", {4'h0, v[7:6], v[4:3]}, {4'h0, lpu, rpu, cm});
         rd(8'h1f, v);
      end
      // all keep-bit and short-mode combinations under both shorts
      for (i = 0; i < 8; i++) begin
         v = 8'hc4 | {5'h0, i[2], 1'b0};
         clr = !i[0] && i[2];
         wr(8'h1e, {6'h0, i[1:0]});
         wr(8'h1f, v);
         @(posedge core_clk) {sp_short_det, hp_short_det} <= 2'b11;
         repeat (3) @(posedge core_clk);
         #1 chk("hp_pu", clr ? 8'h0 : 8'h3, {6'h0, lpu, rpu});
         chk("short_mode", {6'h0, i[2], !i[2]}, {6'h0, pd, lim});
         chk("sp_pu_clear", {7'h0, !i[1]}, {7'h0, sp_pu_clear});
         rd(8'h1f, (clr ? v & 8'h3f : v) | 8'h01);
         @(posedge core_clk) {sp_short_det, hp_short_det} <= 2'b00;
         repeat (2) @(posedge core_clk);
      end
      wr(8'h00, 8'h00);
      for (i = 0; i < 2; i++) begin
         @(posedge core_clk) {pin_gain_valid, pin_gain_code} <= {1'b1, i ? 7'($urandom) : 7'h7e};
         @(posedge core_clk) pin_gain_valid <= 0;
         rd(8'h75, {1'b0, pin_gain_code});
      end
      wr(8'h00, 8'h01);
      rd(8'h1f, 8'hc6);
      end_sim;
   end
   // run needs about 170 cycles
   initial begin
      #200000;
      n_fail++;
      end_sim;
   end
endmodule
bind odp_regbank odp_props chk_i (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .page_sel, .sp_short_det, .hp_short_det, .sp_pu_clear, .left_headphone_driver_pu,
   .right_headphone_driver_pu, .hp_common_mode, .hp_short_pd_mode, .hp_short_current_limit);
